// [bitop_chk.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checker
module bitop_chk (
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic [bitop_pkg::INSN_W-1:0] INSN_IN,
   input wire logic [bitop_pkg::DATA_W-1:0] RD_DATA_IN,
   input wire logic [bitop_pkg::ADDR_W-1:0] RD_ADDR_OUT,
   input wire logic RD_EN_OUT,
   input wire logic [bitop_pkg::ADDR_W-1:0] WR_ADDR_OUT,
   input wire logic [bitop_pkg::DATA_W-1:0] WR_DATA_OUT,
   input wire logic WR_EN_OUT,
   input wire logic FLUSH_OUT,
   input wire logic Q1_OUT,
   input wire logic Q4_OUT
);
   import bitop_pkg::*;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (SRST_IN);
   rd_addr_a: assert property (
      RD_EN_OUT |-> $past(Q1_OUT) && RD_ADDR_OUT == $past(INSN_IN[ADDR_HI:ADDR_LO]))
      else $error("bad read");
   test_flush_a: assert property (
      RD_EN_OUT && $past(INSN_IN[OPC_HI:OPC_LO]) == OPC_TEST_CLEAR |->
      if (RD_DATA_IN[$past(INSN_IN[BSEL_HI:BSEL_LO])]) ##2 !FLUSH_OUT else ##2 FLUSH_OUT)
      else $error("bad skip");
   skip_nop_a: assert property (
      FLUSH_OUT && Q4_OUT |=> (!RD_EN_OUT && !WR_EN_OUT) [*4])
      else $error("skipped word ran");
   wr_cycle_a: assert property (
      WR_EN_OUT |-> Q4_OUT && $past(RD_EN_OUT, 2) &&
      WR_ADDR_OUT == $past(INSN_IN[ADDR_HI:ADDR_LO], 3))
      else $error("bad write");
   rmw_keep_a: assert property (
      WR_EN_OUT |-> WR_DATA_OUT ==
      ($past(RD_DATA_IN, 2) | (8'h01 << $past(INSN_IN[BSEL_HI:BSEL_LO], 3))))
      else $error("bad write data");
endmodule
bind bitop_exec bitop_chk bitop_chk_i (
   .SYS_CLK_IN(SYS_CLK_IN),
   .SRST_IN(SRST_IN),
   .INSN_IN(INSN_IN),
   .RD_DATA_IN(RD_DATA_IN),
   .RD_ADDR_OUT(RD_ADDR_OUT),
   .RD_EN_OUT(RD_EN_OUT),
   .WR_ADDR_OUT(WR_ADDR_OUT),
   .WR_DATA_OUT(WR_DATA_OUT),
   .WR_EN_OUT(WR_EN_OUT),
   .FLUSH_OUT(FLUSH_OUT),
   .Q1_OUT(Q1_OUT),
   .Q4_OUT(Q4_OUT)
);

// [bitop_exec.sv]
`timescale 1ns/1ps
// ==========================================================
// Bit-test-skip-if-clear and bit-set executor
module bitop_exec (
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic [bitop_pkg::INSN_W-1:0] INSN_IN,
   input wire logic [bitop_pkg::DATA_W-1:0] RD_DATA_IN,
   output logic [bitop_pkg::ADDR_W-1:0] RD_ADDR_OUT,
   output logic RD_EN_OUT,
   output logic [bitop_pkg::ADDR_W-1:0] WR_ADDR_OUT,
   output logic [bitop_pkg::DATA_W-1:0] WR_DATA_OUT,
   output logic WR_EN_OUT,
   output logic [bitop_pkg::PC_W-1:0] PC_OUT,
   output logic FLUSH_OUT,
   output logic Q1_OUT,
   output logic Q4_OUT
);
   import bitop_pkg::*;

   // ==========================================================
   // Phase strobes shared with the sequencer
   qphase_if qp ();

   // ==========================================================
   // Pipeline registers
   logic [INSN_W-1:0] insn_r;
   logic is_test_r;
   logic is_set_r;
   logic [DATA_W-1:0] data_r;
   logic [DATA_W-1:0] wr_data_r;
   logic flush_r;
   logic wr_en_r;
   logic skip_r;
   logic [PC_W-1:0] pc_r;

   // ==========================================================
   // Named wires for decode and selection
   logic [ADDR_W-1:0] reg_addr;
   logic [BSEL_W-1:0] bit_sel;
   logic [DATA_W-1:0] sel_onehot;
   logic [DATA_W-1:0] tested_vec;
   logic [DATA_W-1:0] set_data;
   logic tested_bit;
   logic dec_test;
   logic dec_set;
   logic acc_any;
   logic skip_hit;
   logic wr_go;
   logic [PC_W-1:0] pc_nxt;

   // ==========================================================
   // Decode helpers

   // Opcode field match, shared by both decoders
   function automatic logic opc_is(input logic [INSN_W-1:0] w, input logic [3:0] opc);
      opc_is = (w[OPC_HI:OPC_LO] == opc);
   endfunction

   // ==========================================================
   // Phase sequencer

   // Four one-cycle strobes make up one instruction cycle
   qphase_gen qphase_gen_i (
      .clk_in(SYS_CLK_IN),
      .srst_in(SRST_IN),
      .qp(qp.source)
   );

   // ==========================================================
   // Instruction decode

   // Other opcodes leave both kinds low, so they neither read nor write
   // test-clear decode
   assign dec_test = opc_is(INSN_IN, OPC_TEST_CLEAR) && !skip_r;
   assign dec_set = opc_is(INSN_IN, OPC_BIT_SET) && !skip_r;

   // Latch the fetched word at the end of Q1
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         insn_r <= '0;
      end else if (qp.q1) begin
         insn_r <= INSN_IN;
      end
   end

   // Latch the decoded kind; a skipped slot latches neither
   // skipped word idle
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         is_test_r <= 1'b0;
         is_set_r <= 1'b0;
      end else if (qp.q1) begin
         is_test_r <= dec_test;
         is_set_r <= dec_set;
      end
   end

   // Operand fields come straight from the latched word
   assign reg_addr = insn_r[ADDR_HI:ADDR_LO];
   assign bit_sel = insn_r[BSEL_HI:BSEL_LO];

   // ==========================================================
   // Q2 register read

   // Read strobe only for a decoded test or set
   assign acc_any = is_test_r || is_set_r;
   assign RD_EN_OUT = qp.q2 && acc_any;

   // Read address holds from Q1 to the next Q1
   assign RD_ADDR_OUT = reg_addr;

   // Capture the whole register while the read strobe stands
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         data_r <= '0;
      end else if (RD_EN_OUT) begin
         data_r <= RD_DATA_IN;
      end
   end

   // ==========================================================
   // Q3 bit select and merge

   // One select line, one test gate and one merge gate per data bit
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_bit
         assign sel_onehot[gi] = (bit_sel == BSEL_W'(gi));
         assign tested_vec[gi] = data_r[gi] & sel_onehot[gi];
         assign set_data[gi] = data_r[gi] | sel_onehot[gi];
      end
   endgenerate

   // Tested bit picked by the same select lines as the merge
   assign tested_bit = |tested_vec;
   assign skip_hit = is_test_r && !tested_bit;

   // Merged value is held until the Q4 write
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         wr_data_r <= '0;
      end else if (qp.q3) begin
         wr_data_r <= set_data;
      end
   end

   // Flush rises for Q4 and stays through the next Q1, while the fetch loads
   // flush fetched word
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         flush_r <= 1'b0;
      end else if (qp.q3) begin
         flush_r <= skip_hit;
      end else if (qp.q1) begin
         flush_r <= 1'b0;
      end
   end

   // Flush level to the fetch stage
   assign FLUSH_OUT = flush_r;

   // ==========================================================
   // Q4 write-back

   // Write strobe covers Q4 of a bit set only
   assign wr_go = qp.q3 && is_set_r;

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         wr_en_r <= 1'b0;
      end else begin
         wr_en_r <= wr_go;
      end
   end

   // One-cycle write strobe
   assign WR_EN_OUT = wr_en_r;

   // Address and data are stable from Q1 and Q3 through the strobe
   assign WR_ADDR_OUT = reg_addr;
   assign WR_DATA_OUT = wr_data_r;

   // ==========================================================
   // Skip slot

   // Skip arms at the end of Q4 and lasts the whole next cycle
   // whole cycle NOP
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         skip_r <= 1'b0;
      end else if (qp.q4) begin
         skip_r <= flush_r;
      end
   end

   // ==========================================================
   // Program counter

   // One step per instruction cycle; a skipped slot still counts
   assign pc_nxt = pc_r + PC_ONE;

   // Counter moves at the end of Q4
   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         pc_r <= PC_RESET;
      end else if (qp.q4) begin
         pc_r <= pc_nxt;
      end
   end

   // Counter value to the fetch stage
   assign PC_OUT = pc_r;

   // ==========================================================
   // Phase strobes for the fetch stage
   assign Q1_OUT = qp.q1;
   assign Q4_OUT = qp.q4;
endmodule

// [bitop_exec_tb.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench for the bit test and bit set executor
module bitop_exec_tb;
   import bitop_pkg::*;
   logic clk = 0;
   logic srst = 1;
   logic [INSN_W-1:0] insn = '0;
   logic [DATA_W-1:0] rd_data = '0;
   logic [DATA_W-1:0] mem [128];
   logic [ADDR_W-1:0] rd_addr, wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [PC_W-1:0] pc;
   logic rd_en, wr_en, flush, q1, q4;
   logic seen = 0;
   int n_errors = 0;
   int cmp_count = 0;
   always #10 clk = ~clk;
   bitop_exec bitop_exec_i (.SYS_CLK_IN(clk), .SRST_IN(srst), .INSN_IN(insn),
      .RD_DATA_IN(rd_data), .RD_ADDR_OUT(rd_addr), .RD_EN_OUT(rd_en), .WR_ADDR_OUT(wr_addr),
      .WR_DATA_OUT(wr_data), .WR_EN_OUT(wr_en), .PC_OUT(pc), .FLUSH_OUT(flush),
      .Q1_OUT(q1), .Q4_OUT(q4));
   // Register file answers only while read is enabled
   always @(negedge clk) rd_data <= rd_en ? mem[rd_addr] : ~mem[rd_addr];
   // Register file write and skip flag
   always @(posedge clk) begin
      if (wr_en) mem[wr_addr] <= wr_data;
      if (flush) seen <= 1'b1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One instruction slot from Q1
   task automatic exec(input logic [3:0] op, input logic [2:0] b, input logic [6:0] f);
      while (q1 !== 1'b1) @(negedge clk);
      insn = {op, b, f};
      repeat (4) @(negedge clk);
   endtask
   // Set edge bits 7 and 0 at addresses 5 and 127
   task automatic t_set;
      mem[5] = 8'h0a;
      mem[127] = 8'hfe;
      exec(OPC_BIT_SET, 3'h7, 7'h05);
      exec(OPC_BIT_SET, 3'h0, 7'h7f);
      chk(mem[5], 8'h8a);
      chk(mem[127], 8'hff);
   endtask
   // Clear bit skips next word, set bit does not
   task automatic t_skip;
      logic [PC_W-1:0] pc0;
      mem[9] = 8'hf7;
      pc0 = pc;
      exec(OPC_TEST_CLEAR, 3'h3, 7'h09);
      exec(OPC_BIT_SET, 3'h1, 7'h14);
      chk(seen, 1'b1);
      chk(mem[20], 8'h00);
      chk(pc - pc0, 16'h0002);
      seen = 1'b0;
      exec(4'h7, 3'h3, 7'h09);
      exec(OPC_TEST_CLEAR, 3'h2, 7'h09);
      exec(OPC_BIT_SET, 3'h1, 7'h14);
      chk(seen, 1'b0);
      chk(mem[20], 8'h02);
   endtask
   task automatic conclude;
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (20) @(negedge clk);
      srst = 0;
      t_set();
      t_skip();
      conclude();
   end
   // Watchdog far above the test length
   initial begin
      #20us;
      n_errors++;
      conclude();
   end
endmodule

// [bitop_pkg.sv]
// Functional notes
// - Bit-test-skip-if-clear is word 01 10 bbb fffffff and leaves status untouched.
// - A tested bit of one ends the test in one cycle and the next word runs normally.
// - A tested bit of zero discards the fetched next word and runs a full NOP cycle.
// - Bit set (01 01 bbb fffffff) forces the selected bit to one, writing in Q4.
package bitop_pkg;
   // ==========================================================
   // Instruction word layout
   localparam int INSN_W = 14;
   localparam int ADDR_W = 7;
   localparam int BSEL_W = 3;
   localparam int DATA_W = 8;
   localparam int PC_W = 13;
   localparam int OPC_HI = 13;
   localparam int OPC_LO = 10;
   localparam int BSEL_HI = 9;
   localparam int BSEL_LO = 7;
   localparam int ADDR_HI = 6;
   localparam int ADDR_LO = 0;
   localparam logic [3:0] OPC_TEST_CLEAR = 4'h6;
   localparam logic [3:0] OPC_BIT_SET = 4'h5;
   // ==========================================================
   // Quarter phases, one-hot
   typedef enum logic [3:0] {
      Q1 = 4'h1,
      Q2 = 4'h2,
      Q3 = 4'h4,
      Q4 = 4'h8
   } quarter_t;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
endpackage

// [qphase_gen.sv]
`timescale 1ns/1ps
// ==========================================================
// Quarter-phase sequencer
module qphase_gen (
   input wire logic clk_in,
   input wire logic srst_in,
   qphase_if.source qp
);
   import bitop_pkg::*;
   quarter_t state_r;
   quarter_t state_nxt;
   // Next phase in ring order
   always_comb begin
      unique case (state_r)
         Q1: state_nxt = Q2;
         Q2: state_nxt = Q3;
         Q3: state_nxt = Q4;
         Q4: state_nxt = Q1;
         default: state_nxt = Q1;
      endcase
   end
   // Phase register
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_r <= Q1;
      end else begin
         state_r <= state_nxt;
      end
   end
   // Strobe outputs
   assign qp.q1 = (state_r == Q1);
   assign qp.q2 = (state_r == Q2);
   assign qp.q3 = (state_r == Q3);
   assign qp.q4 = (state_r == Q4);
endmodule

// [qphase_if.sv]
`timescale 1ns/1ps
// ==========================================================
// Quarter-phase strobes shared between sequencer and executor
interface qphase_if;
   logic q1;
   logic q2;
   logic q3;
   logic q4;
   modport source (output q1, output q2, output q3, output q4);
   modport sink (input q1, input q2, input q3, input q4);
endinterface
